// >>> hdl/timer16_map.svh
// Register offsets, field positions, reset values and timing counts of the timer
`ifndef TIMER16_MAP_SVH
`define TIMER16_MAP_SVH
`define ADDR_COUNT 4'h0
`define ADDR_CAPCMP_A 4'h1
`define ADDR_CAPCMP_B 4'h2
`define ADDR_MODE 4'h3
`define ADDR_CAPCMP_CTRL 4'h4
`define ADDR_OUTPUT_CTRL 4'h5
`define ADDR_PRESCALER 4'h6
`define MODE_OVF 0
`define MODE_OP_LO 2
`define MODE_OP_HI 3
`define CC_A_CAPTURE 0
`define CC_REV_PHASE 1
`define CC_B_CAPTURE 2
`define OC_ENABLE 0
`define OC_A_TOGGLE 1
`define OC_LVL_RESET 2
`define OC_LVL_SET 3
`define OC_B_TOGGLE 4
`define OC_OS_ENABLE 5
`define OC_OS_TRIGGER 6
`define PS_CLK_LO 0
`define PS_CLK_HI 1
`define PS_ES_A_LO 4
`define PS_ES_A_HI 5
`define PS_ES_B_LO 6
`define PS_ES_B_HI 7
`define CLK_SEL_EXT_A 2'h3
`define RST_OUTPUT_CTRL 8'h00
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`define COUNT_MAX 16'hffff
`define COUNT_ONE 16'h0001
`define DIV_WIDTH 2
`endif

// >>> hdl/timer16_pkg.sv
// Types shared by the timer design and its bench
package timer16_pkg;
	typedef enum logic [1:0] {op_stopped, op_free_run, op_clear_edge, op_clear_match} op_mode_type;
	typedef enum logic [1:0] {edge_falling, edge_rising, edge_none, edge_both} edge_sel_type;
endpackage

// >>> hdl/timer16_capture_compare_output.sv
// 16-bit timer with two capture/compare registers and one output pin
// Operation
// R1: Mode 01 free-runs; 00 stops and clears; others are clear-and-start modes.
// R2: Mode 10 clears on trigger A edge, capturing count into register B.
// R3: Register A captures on trigger B edge or reverse phase of A.
// R4: Register B captures on each valid trigger A edge.
// R5: Software leaves compare registers alone while running.
// R6: Duty change on B follows its match, with toggle disabled meanwhile.
// R7: Level bits: 00 unchanged, 01 low, 10 high, 11 ignored.
// R8: Level bits act only while stopped; writes while running are ignored. Code keeps such writes and applies them once stopped.
// R9: Output starts from preset level; toggles on enabled matches.
// R10: Output control stays 00H in counting and measuring modes.
// R11: Pulse-pattern compare values differ and are nonzero.
// R12: First match after start may come one count clock late.
// R13: Clear-on-match needs nonzero values in both registers.
// R14: Capture beside a read completes; read only after capture interrupt.
// R15: Capture/compare contents are not promised after stop.
// R16: Edge selects are changed only while stopped.
// R17: One-shot retriggers after active level; not in clear-on-match mode.
// R18: Match A at FFFFH in clear-on-match mode also sets overflow.
// R19: Overflow clear before count reaches 0001H is ineffective.
// R20: With trigger A as count clock, A-triggered captures are dropped.
// R21: Trigger pulses last over two count clocks.
// R22: Capture on count tick; its interrupt on the following tick.
// R23: Reverse-phase capture raises no interrupt; B edge then pulses match-A.
// R24: First enable after reset sees a high trigger as rising edge.
`timescale 1ns/10ps
`include "timer16_map.svh"
module timer16_capture_compare_output (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [3:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr_strobe,
	input wire logic rd_strobe,
	output logic [15:0] rdata,
	input wire logic trigger_input_a,
	input wire logic trigger_input_b,
	output logic timer_output_pin,
	output logic irq_match_a,
	output logic irq_match_b
);
	import timer16_pkg::*;

	// ----------------------------------------
	// Registers and state
	// ----------------------------------------
	logic [15:0] count_register_q;
	logic [15:0] capcmp_reg_a_q;
	logic [15:0] capcmp_reg_b_q;
	logic [1:0] op_mode_q;
	logic overflow_flag_q;
	logic [2:0] capcmp_ctrl_reg_q;
	logic [7:0] output_ctrl_reg_q;
	logic [7:0] prescaler_sel_reg_q;
	logic out_level_q;
	logic [1:0] sync_a_q;
	logic [1:0] sync_b_q;
	logic prev_a_q;
	logic prev_b_q;
	logic started_q;
	logic [7:0] div_q;
	logic tick_q;
	logic edge_a_pend_q;
	logic rev_a_pend_q;
	logic edge_b_pend_q;
	logic cap_irq_a_q;
	logic cap_irq_b_q;
	logic oneshot_armed_q;
	logic oneshot_req_q;
	logic wrapped_q;
	logic [15:0] rdata_q;
	logic irq_a_q;
	logic irq_b_q;
	logic pin_q;

	op_mode_type op_mode;
	edge_sel_type es_a;
	edge_sel_type es_b;
	logic running;
	logic wr_mode;
	logic rise_a, fall_a, rise_b, fall_b;
	logic valid_a, reverse_a, valid_b;
	logic ext_clk;
	logic tick;
	logic a_is_cap, b_is_cap, rev_sel;
	logic cap_a_now, cap_b_now, b_ext_irq;
	logic match_a, match_b;
	logic clear_now;
	logic oneshot_en;
	logic toggle_a, toggle_b;

	assign op_mode = op_mode_type'(op_mode_q);
	assign running = op_mode != op_stopped;
	assign wr_mode = wr_strobe && addr == `ADDR_MODE;
	assign es_a = edge_sel_type'(prescaler_sel_reg_q[`PS_ES_A_HI:`PS_ES_A_LO]);
	assign es_b = edge_sel_type'(prescaler_sel_reg_q[`PS_ES_B_HI:`PS_ES_B_LO]);
	assign a_is_cap = capcmp_ctrl_reg_q[`CC_A_CAPTURE];
	assign b_is_cap = capcmp_ctrl_reg_q[`CC_B_CAPTURE];
	assign rev_sel = capcmp_ctrl_reg_q[`CC_REV_PHASE];
	assign oneshot_en = output_ctrl_reg_q[`OC_OS_ENABLE];
	assign ext_clk = prescaler_sel_reg_q[`PS_CLK_HI:`PS_CLK_LO] == `CLK_SEL_EXT_A;

	// ----------------------------------------
	// Trigger synchronisers and edge detection
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			sync_a_q <= 2'h0;
			sync_b_q <= 2'h0;
		end else begin
			sync_a_q <= {sync_a_q[0], trigger_input_a};
			sync_b_q <= {sync_b_q[0], trigger_input_b};
		end
	end

	// Edge history resets low, holds until the first start, then tracks even while stopped
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			prev_a_q <= 1'b0;
			prev_b_q <= 1'b0;
			started_q <= 1'b0;
		end else begin
			if (running) begin
				started_q <= 1'b1;
			end
			if (running || started_q) begin // R24
				prev_a_q <= sync_a_q[1];
				prev_b_q <= sync_b_q[1];
			end
		end
	end

	assign rise_a = sync_a_q[1] && !prev_a_q;
	assign fall_a = !sync_a_q[1] && prev_a_q;
	assign rise_b = sync_b_q[1] && !prev_b_q;
	assign fall_b = !sync_b_q[1] && prev_b_q;
	// Triggers are ignored while stopped
	assign valid_a = running && ((es_a == edge_rising && rise_a) || (es_a == edge_falling && fall_a)
		|| (es_a == edge_both && (rise_a || fall_a)));
	assign reverse_a = running && ((es_a == edge_rising && fall_a)
		|| (es_a == edge_falling && rise_a));
	assign valid_b = running && ((es_b == edge_rising && rise_b) || (es_b == edge_falling && fall_b)
		|| (es_b == edge_both && (rise_b || fall_b)));

	// ----------------------------------------
	// Count clock
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (sys_rst || !running) begin
			div_q <= `RST_BYTE;
		end else begin
			div_q <= div_q + 8'h01;
		end
	end

	// Divider restarts at start, so the first tick may slip a count clock
	always_comb begin
		unique case (prescaler_sel_reg_q[`PS_CLK_HI:`PS_CLK_LO])
			2'h0: tick = running;
			2'h1: tick = running && div_q[0];
			2'h2: tick = running && div_q[1:0] == 2'h3;
			default: tick = valid_a;
		endcase
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			tick_q <= 1'b0;
		end else begin
			tick_q <= tick; // R12
		end
	end

	// ----------------------------------------
	// Capture
	// ----------------------------------------
	// Edges wait for the next count tick; with A as count clock the A edges are dropped
	always_ff @(posedge clock) begin
		if (sys_rst || !running) begin
			edge_a_pend_q <= 1'b0;
			rev_a_pend_q <= 1'b0;
			edge_b_pend_q <= 1'b0;
		end else begin
			edge_a_pend_q <= !ext_clk && (valid_a || (edge_a_pend_q && !tick)); // R20
			rev_a_pend_q <= !ext_clk && (reverse_a || (rev_a_pend_q && !tick)); // R20
			edge_b_pend_q <= valid_b || (edge_b_pend_q && !tick);
		end
	end

	assign cap_b_now = tick && edge_a_pend_q && (b_is_cap || op_mode == op_clear_edge); // R4
	assign cap_a_now = tick && a_is_cap && (rev_sel ? rev_a_pend_q : edge_b_pend_q); // R3
	assign b_ext_irq = tick && a_is_cap && rev_sel && edge_b_pend_q; // R23
	assign match_a = tick && !a_is_cap && count_register_q == capcmp_reg_a_q;
	assign match_b = tick && !b_is_cap && count_register_q == capcmp_reg_b_q;
	assign clear_now = (op_mode == op_clear_edge && tick && edge_a_pend_q)
		|| (op_mode == op_clear_match && match_a); // R2

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			capcmp_reg_a_q <= `RST_WORD;
		end else if (cap_a_now) begin
			capcmp_reg_a_q <= count_register_q; // R3
		end else if (wr_strobe && addr == `ADDR_CAPCMP_A) begin
			capcmp_reg_a_q <= wdata; // R15
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			capcmp_reg_b_q <= `RST_WORD;
		end else if (cap_b_now) begin
			capcmp_reg_b_q <= count_register_q; // R4
		end else if (wr_strobe && addr == `ADDR_CAPCMP_B) begin
			capcmp_reg_b_q <= wdata;
		end
	end

	// Capture interrupts follow one count tick after the capture
	always_ff @(posedge clock) begin
		if (sys_rst || !running) begin
			cap_irq_a_q <= 1'b0;
			cap_irq_b_q <= 1'b0;
		end else begin
			cap_irq_a_q <= (cap_a_now && !rev_sel) || b_ext_irq || (cap_irq_a_q && !tick); // R22
			cap_irq_b_q <= cap_b_now || (cap_irq_b_q && !tick); // R22
		end
	end

	// ----------------------------------------
	// Counter, mode and overflow
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (sys_rst || !running) begin
			count_register_q <= `RST_WORD; // R1
		end else if (clear_now || (oneshot_req_q && op_mode != op_clear_match)) begin
			count_register_q <= `RST_WORD; // R2
		end else if (tick) begin
			count_register_q <= count_register_q + `COUNT_ONE; // R1
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			op_mode_q <= 2'h0;
		end else if (wr_mode) begin
			op_mode_q <= wdata[`MODE_OP_HI:`MODE_OP_LO]; // R1
		end
	end

	// Wrapped marks the window from a wrap until the count reaches 0001H
	always_ff @(posedge clock) begin
		if (sys_rst || !running) begin
			wrapped_q <= 1'b0;
		end else if (tick && count_register_q == `COUNT_MAX) begin
			wrapped_q <= 1'b1; // R18
		end else if (tick) begin
			wrapped_q <= 1'b0;
		end
	end

	// A new overflow wins over a software clear
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			overflow_flag_q <= 1'b0;
		end else if (tick && count_register_q == `COUNT_MAX) begin
			overflow_flag_q <= 1'b1; // R18
		end else if (wr_mode && !wdata[`MODE_OVF]) begin
			overflow_flag_q <= wrapped_q; // R19
		end
	end

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			capcmp_ctrl_reg_q <= 3'h0;
			prescaler_sel_reg_q <= `RST_BYTE;
		end else begin
			if (wr_strobe && addr == `ADDR_CAPCMP_CTRL) begin
				capcmp_ctrl_reg_q <= wdata[2:0];
			end
			if (wr_strobe && addr == `ADDR_PRESCALER) begin
				prescaler_sel_reg_q <= wdata[7:0];
			end
		end
	end

	// Level bits kept but act only while stopped; trigger is a strobe, reads 0
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			output_ctrl_reg_q <= `RST_OUTPUT_CTRL;
		end else if (wr_strobe && addr == `ADDR_OUTPUT_CTRL) begin
			output_ctrl_reg_q <= {2'b00, wdata[5:0]};
		end
	end

	// ----------------------------------------
	// One-shot and timer output
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (sys_rst || !running) begin
			oneshot_req_q <= 1'b0;
		end else begin
			oneshot_req_q <= oneshot_en && wr_strobe && addr == `ADDR_OUTPUT_CTRL
				&& wdata[`OC_OS_TRIGGER]; // R17
		end
	end

	// No one-shot in clear-on-match mode; a retrigger mid-pulse restarts it
	always_ff @(posedge clock) begin
		if (sys_rst || !running || !oneshot_en) begin
			oneshot_armed_q <= 1'b0;
		end else if (oneshot_req_q && op_mode != op_clear_match) begin
			oneshot_armed_q <= 1'b1; // R17
		end else if (match_b) begin
			oneshot_armed_q <= 1'b0;
		end
	end

	assign toggle_a = match_a && output_ctrl_reg_q[`OC_A_TOGGLE] && (!oneshot_en || oneshot_armed_q);
	assign toggle_b = match_b && output_ctrl_reg_q[`OC_B_TOGGLE] && (!oneshot_en || oneshot_armed_q);

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			out_level_q <= 1'b0;
		end else if (!running) begin
			unique case ({output_ctrl_reg_q[`OC_LVL_SET], output_ctrl_reg_q[`OC_LVL_RESET]})
				2'h1: out_level_q <= 1'b0; // R7
				2'h2: out_level_q <= 1'b1; // R7
				default: out_level_q <= out_level_q; // R8
			endcase
		end else if (toggle_a ^ toggle_b) begin
			out_level_q <= !out_level_q; // R9
		end
	end

	// ----------------------------------------
	// Outputs and read path
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pin_q <= 1'b0;
			irq_a_q <= 1'b0;
			irq_b_q <= 1'b0;
		end else begin
			pin_q <= out_level_q && output_ctrl_reg_q[`OC_ENABLE];
			irq_a_q <= match_a || (cap_irq_a_q && tick); // R23
			irq_b_q <= match_b || (cap_irq_b_q && tick);
		end
	end

	// A capture racing a read still lands; the read word may be stale
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			rdata_q <= `RST_WORD;
		end else if (rd_strobe) begin
			unique case (addr)
				`ADDR_COUNT: rdata_q <= count_register_q;
				`ADDR_CAPCMP_A: rdata_q <= capcmp_reg_a_q; // R14
				`ADDR_CAPCMP_B: rdata_q <= capcmp_reg_b_q; // R14
				`ADDR_MODE: rdata_q <= {12'h000, op_mode_q, 1'b0, overflow_flag_q};
				`ADDR_CAPCMP_CTRL: rdata_q <= {13'h0000, capcmp_ctrl_reg_q};
				`ADDR_OUTPUT_CTRL: rdata_q <= {8'h00, output_ctrl_reg_q};
				`ADDR_PRESCALER: rdata_q <= {8'h00, prescaler_sel_reg_q};
				default: rdata_q <= `RST_WORD;
			endcase
		end else begin
			rdata_q <= `RST_WORD;
		end
	end

	assign rdata = rdata_q;
	assign timer_output_pin = pin_q;
	assign irq_match_a = irq_a_q;
	assign irq_match_b = irq_b_q;
endmodule

// >>> dv/timer16_sva.sv
// Port-level checker for the timer
`timescale 1ns/10ps
`include "timer16_map.svh"
module timer16_sva (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [3:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr_strobe,
	input wire logic rd_strobe,
	input wire logic [15:0] rdata,
	input wire logic trigger_input_a,
	input wire logic trigger_input_b,
	input wire logic timer_output_pin,
	input wire logic irq_match_a,
	input wire logic irq_match_b
);
	logic [1:0] mode_q;
	logic [3:0] oc_q;
	// ------
	// Shadows, same write-next-cycle timing as the design
	// ------
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			mode_q <= 2'h0;
		end else if (wr_strobe && addr == `ADDR_MODE) begin
			mode_q <= wdata[3:2];
		end
	end
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			oc_q <= 4'h0;
		end else if (wr_strobe && addr == `ADDR_OUTPUT_CTRL) begin
			oc_q <= {wdata[5], wdata[4], wdata[1], wdata[0]};
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	rd_idle_zero_a: assert property (!$past(rd_strobe) |-> rdata == 16'h0000)
		else $error("read data outside answer cycle");
	unmapped_rd_zero_a: assert property (rd_strobe && addr > `ADDR_PRESCALER |=> rdata == 16'h0000)
		else $error("unmapped read not zero");
	stop_count_zero_a: assert property (rd_strobe && addr == `ADDR_COUNT && mode_q == 2'h0 &&
		$past(mode_q) == 2'h0 |=> rdata == 16'h0000) else $error("stopped count not zero");
	stop_no_irq_a: assert property (mode_q == 2'h0 && $past(mode_q) == 2'h0 &&
		$past(mode_q, 2) == 2'h0 |-> !irq_match_a && !irq_match_b) else $error("irq while stopped");
	pin_off_low_a: assert property (!oc_q[0] && !$past(oc_q[0]) && !$past(oc_q[0], 2)
		|-> !timer_output_pin) else $error("pin high while disabled");
	level_set_a: assert property (wr_strobe && addr == `ADDR_OUTPUT_CTRL &&
		wdata[3:0] == 4'h9 && mode_q == 2'h0 |-> ##[1:4] timer_output_pin) else $error("set lost");
	level_reset_a: assert property (wr_strobe && addr == `ADDR_OUTPUT_CTRL &&
		wdata[3:0] == 4'h5 && mode_q == 2'h0 |-> ##[1:4] !timer_output_pin) else $error("reset lost");
	run_level_kept_a: assert property (wr_strobe && addr == `ADDR_OUTPUT_CTRL && mode_q != 2'h0
		&& wdata[6:4] == 3'h0 && wdata[1:0] == 2'h1 && oc_q == 4'h1 |=> $stable(timer_output_pin)[*3])
		else $error("level bits acted while running");
	irq_a_pulse_a: assert property (irq_match_a |=> !irq_match_a)
		else $error("irq a longer than one cycle");
	irq_b_pulse_a: assert property (irq_match_b |=> !irq_match_b)
		else $error("irq b longer than one cycle");
	cover property (irq_match_a);
	cover property (irq_match_b);
	cover property ($rose(timer_output_pin));
endmodule

// >>> dv/trigger_partner.sv
// Trigger sources facing the timer's input pins
`timescale 1ns/10ps
module trigger_partner (
	input wire logic clock,
	input wire logic fire_a,
	input wire logic fire_b,
	input wire logic [7:0] width,
	input wire logic hold_a,
	output logic trigger_input_a,
	output logic trigger_input_b
);
	int cnt_a = 0;
	int cnt_b = 0;
	// Width always above two count clocks, else captures go astray
	always @(posedge clock) begin
		cnt_a <= fire_a ? int'(width) : (cnt_a > 0 ? cnt_a - 1 : 0);
		cnt_b <= fire_b ? int'(width) : (cnt_b > 0 ? cnt_b - 1 : 0);
	end
	assign trigger_input_a = hold_a || cnt_a > 0;
	assign trigger_input_b = cnt_b > 0;
endmodule

// >>> dv/tb_top.sv
// Self-checking bench for the timer
`timescale 1ns/10ps
`include "timer16_map.svh"
module tb_top;
	import timer16_pkg::*;
	logic clock = 0, sys_rst = 1, wr_strobe = 0, rd_strobe = 0, fire_a = 0, fire_b = 0, hold_a = 0;
	logic [3:0] addr = 4'h0;
	logic [15:0] wdata = 16'h0000, rdata, ra, rb, rc;
	logic [7:0] width = 8'h00;
	logic trigger_input_a, trigger_input_b, timer_output_pin, irq_match_a, irq_match_b;
	int err_total = 0, tests_run = 0, cyc = 0, na = 0, nb = 0, a0, b0, d, hi;
	int unsigned seed = 63;
	int ta[$];
	timer16_capture_compare_output timer16_capture_compare_output_i (.clock(clock),
		.sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr_strobe(wr_strobe),
		.rd_strobe(rd_strobe), .rdata(rdata), .trigger_input_a(trigger_input_a),
		.trigger_input_b(trigger_input_b), .timer_output_pin(timer_output_pin),
		.irq_match_a(irq_match_a), .irq_match_b(irq_match_b));
	trigger_partner trigger_partner_i (.clock(clock), .fire_a(fire_a), .fire_b(fire_b),
		.width(width), .hold_a(hold_a), .trigger_input_a(trigger_input_a),
		.trigger_input_b(trigger_input_b));
	initial forever #25 clock = ~clock;
	function automatic int xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return int'(seed);
	endfunction
	function automatic logic [15:0] md(op_mode_type o);
		return {12'h000, o, 2'b00};
	endfunction
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge clock);
		addr <= a;
		wdata <= v;
		wr_strobe <= 1'b1;
		@(posedge clock);
		wr_strobe <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] v);
		@(posedge clock);
		addr <= a;
		rd_strobe <= 1'b1;
		@(posedge clock);
		rd_strobe <= 1'b0;
		#1;
		v = rdata;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic fire(input logic b, input logic [7:0] w);
		@(posedge clock);
		width <= w;
		fire_a <= !b;
		fire_b <= b;
		@(posedge clock);
		fire_a <= 1'b0;
		fire_b <= 1'b0;
	endtask
	task automatic wait_a(input int n, input int lim);
		for (int k = 0; k < lim && ta.size() < n; k++) tick(1);
	endtask
	task automatic hi_cnt(input int n);
		hi = 0;
		repeat (n) begin
			tick(1);
			hi += int'(timer_output_pin);
		end
	endtask
	task automatic done(input int n);
		$display("test %0d done", n);
	endtask
	task automatic close_out();
		$display("compares %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ------
	// Event model and hang guard; the long wrap test sets the ceiling
	// ------
	always @(posedge clock) begin
		cyc++;
		if (irq_match_a === 1'b1) begin
			na++;
			ta.push_back(cyc);
		end
		if (irq_match_b === 1'b1) nb++;
		if (cyc == 90000) begin
			err_total++;
			close_out();
		end
	end
	initial begin
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		for (int i = 0; i < 16; i++) begin
			rd(i[3:0], rc);
			check(rc, 16'h0000);
		end
		d = xs();
		wr(`ADDR_CAPCMP_A, d[15:0]);
		rd(`ADDR_CAPCMP_A, rc);
		check(rc, d[15:0]);
		done(1);
		wr(`ADDR_OUTPUT_CTRL, 16'h0009);
		tick(4);
		check(16'(timer_output_pin), 16'h0001);
		wr(`ADDR_OUTPUT_CTRL, 16'h0001);
		tick(4);
		check(16'(timer_output_pin), 16'h0001);
		wr(`ADDR_OUTPUT_CTRL, 16'h0005);
		tick(4);
		check(16'(timer_output_pin), 16'h0000);
		wr(`ADDR_OUTPUT_CTRL, 16'h0009);
		wr(`ADDR_OUTPUT_CTRL, 16'h0001);
		wr(`ADDR_MODE, md(op_free_run));
		wr(`ADDR_OUTPUT_CTRL, 16'h0005);
		tick(4);
		check(16'(timer_output_pin), 16'h0001);
		wr(`ADDR_MODE, 16'h0000);
		done(2);
		wr(`ADDR_OUTPUT_CTRL, 16'h0009);
		wr(`ADDR_CAPCMP_A, 16'h0005);
		wr(`ADDR_OUTPUT_CTRL, 16'h0003);
		ta.delete();
		wr(`ADDR_MODE, md(op_clear_match));
		check(16'(timer_output_pin), 16'h0001);
		wait_a(3, 100);
		check(16'(ta[2] - ta[1]), 16'(5 + 1));
		tick(3);
		check(16'(timer_output_pin), 16'h0000);
		wr(`ADDR_MODE, 16'h0000);
		done(3);
		wr(`ADDR_OUTPUT_CTRL, 16'h0000);
		wr(`ADDR_CAPCMP_A, 16'hffff);
		a0 = na;
		wr(`ADDR_MODE, md(op_clear_match));
		// Clear lands one count after the wrap, inside the dead window
		tick(65535);
		wr(`ADDR_MODE, md(op_clear_match));
		rd(`ADDR_MODE, rc);
		check(rc, 16'h000d);
		tick(10);
		check(16'(na - a0), 16'h0001);
		wr(`ADDR_MODE, md(op_clear_match));
		rd(`ADDR_MODE, rc);
		check(rc, 16'h000c);
		wr(`ADDR_MODE, 16'h0000);
		done(4);
		wr(`ADDR_PRESCALER, 16'h0050);
		wr(`ADDR_CAPCMP_CTRL, 16'h0005);
		wr(`ADDR_MODE, md(op_free_run));
		a0 = na;
		b0 = nb;
		d = 20 + (xs() & 63);
		fire(1'b0, 8'h08);
		tick(d - 2);
		fire(1'b1, 8'h08);
		tick(40);
		check(16'(na - a0), 16'h0001);
		check(16'(nb - b0), 16'h0001);
		rd(`ADDR_CAPCMP_A, ra);
		rd(`ADDR_CAPCMP_B, rb);
		check(ra - rb, 16'(d));
		wr(`ADDR_MODE, 16'h0000);
		done(5);
		wr(`ADDR_CAPCMP_CTRL, 16'h0007);
		wr(`ADDR_MODE, md(op_free_run));
		a0 = na;
		b0 = nb;
		d = 10 + (xs() & 31);
		fire(1'b0, 8'(d));
		tick(60);
		check(16'(na - a0), 16'h0000);
		check(16'(nb - b0), 16'h0001);
		rd(`ADDR_CAPCMP_A, ra);
		rd(`ADDR_CAPCMP_B, rb);
		check(ra - rb, 16'(d));
		fire(1'b1, 8'h08);
		tick(40);
		check(16'(na - a0), 16'h0001);
		rd(`ADDR_CAPCMP_A, rc);
		check(rc, ra);
		wr(`ADDR_MODE, 16'h0000);
		done(6);
		wr(`ADDR_CAPCMP_CTRL, 16'h0004);
		wr(`ADDR_MODE, md(op_clear_edge));
		tick(200);
		b0 = nb;
		fire(1'b0, 8'h08);
		tick(30);
		check(16'(nb - b0), 16'h0001);
		rd(`ADDR_COUNT, rc);
		check(16'(rc < 16'd40), 16'h0001);
		rd(`ADDR_CAPCMP_B, rb);
		check(16'(rb > 16'd190), 16'h0001);
		wr(`ADDR_MODE, 16'h0000);
		done(7);
		@(posedge clock);
		sys_rst <= 1'b1;
		hold_a <= 1'b1;
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		wr(`ADDR_PRESCALER, 16'h0010);
		wr(`ADDR_CAPCMP_CTRL, 16'h0004);
		b0 = nb;
		wr(`ADDR_MODE, md(op_free_run));
		tick(20);
		check(16'(nb - b0), 16'h0001);
		wr(`ADDR_MODE, 16'h0000);
		wr(`ADDR_MODE, md(op_free_run));
		tick(20);
		check(16'(nb - b0), 16'h0001);
		done(8);
		wr(`ADDR_MODE, 16'h0000);
		hold_a <= 1'b0;
		wr(`ADDR_CAPCMP_CTRL, 16'h0000);
		wr(`ADDR_CAPCMP_A, 16'h0009);
		wr(`ADDR_CAPCMP_B, 16'h0003);
		wr(`ADDR_OUTPUT_CTRL, 16'h0005);
		wr(`ADDR_OUTPUT_CTRL, 16'h0013);
		wr(`ADDR_MODE, md(op_clear_match));
		tick(5);
		hi_cnt(40);
		check(16'(hi), 16'd24);
		b0 = nb;
		for (int k = 0; k < 20 && nb == b0; k++) tick(1);
		// Duty change right after a B match, toggle held off meanwhile
		wr(`ADDR_OUTPUT_CTRL, 16'h0003);
		wr(`ADDR_CAPCMP_B, 16'h0005);
		wr(`ADDR_OUTPUT_CTRL, 16'h0013);
		hi_cnt(40);
		check(16'(hi), 16'd16);
		wr(`ADDR_MODE, 16'h0000);
		done(9);
		wr(`ADDR_OUTPUT_CTRL, 16'h0005);
		wr(`ADDR_CAPCMP_A, 16'h0004);
		wr(`ADDR_CAPCMP_B, 16'h000a);
		wr(`ADDR_OUTPUT_CTRL, 16'h0033);
		wr(`ADDR_MODE, md(op_free_run));
		for (int j = 0; j < 2; j++) begin
			wr(`ADDR_OUTPUT_CTRL, 16'h0073);
			hi_cnt(30);
			check(16'(hi), 16'd6);
		end
		rd(`ADDR_OUTPUT_CTRL, rc);
		check(rc, 16'h0033);
		wr(`ADDR_MODE, 16'h0000);
		done(10);
		wr(`ADDR_OUTPUT_CTRL, 16'h0000);
		wr(`ADDR_PRESCALER, 16'h0013);
		wr(`ADDR_CAPCMP_CTRL, 16'h0004);
		b0 = nb;
		wr(`ADDR_MODE, md(op_free_run));
		repeat (3) begin
			fire(1'b0, 8'h08);
			tick(20);
		end
		rd(`ADDR_COUNT, rc);
		check(rc, 16'h0003);
		check(16'(nb - b0), 16'h0000);
		wr(`ADDR_MODE, 16'h0000);
		done(11);
		close_out();
	end
endmodule
bind timer16_capture_compare_output timer16_sva timer16_sva_i (.clock(clock), .sys_rst(sys_rst),
	.addr(addr), .wdata(wdata), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata),
	.trigger_input_a(trigger_input_a), .trigger_input_b(trigger_input_b),
	.timer_output_pin(timer_output_pin), .irq_match_a(irq_match_a), .irq_match_b(irq_match_b));
